// ---- design/dic_pkg.sv ----
/*
 package for the dac / idac output control block: offsets, fields, resets, types.
 assumes a 32-bit ahb-lite slave with byte addresses in the low 8 bits.
*/
package dic_pkg;
   localparam int N_VDAC = 12;
   localparam int N_IDAC = 5;
   localparam int CODE_W = 12;
   localparam int FRAC_W = 4;
   localparam int IDAC_W = 11;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFF_VDAC_CODE = 8'h00;
   localparam logic [7:0] OFF_VDAC_CTL = 8'h40;
   localparam logic [7:0] OFF_IDAC_CODE = 8'h80;
   localparam logic [7:0] OFF_IDAC_CTL = 8'hA0;
   localparam logic [7:0] OFF_STATUS = 8'hA4;
   localparam logic [7:0] OFF_IRQ_STAT = 8'hA8;
   localparam logic [7:0] OFF_IRQ_MASK = 8'hAC;
   // field positions
   localparam int CODE_LSB = 16;
   localparam int CODE_MSB = 27;
   localparam int FRAC_LSB = 12;
   localparam int FRAC_MSB = 15;
   localparam int CTL_RANGE_LSB = 0;
   localparam int CTL_MODE_BIT = 3;
   localparam int CTL_UPD_BIT = 5;
   localparam int IDAC_EN_BIT = 0;
   localparam int IDAC_SW_BIT = 1;
   localparam int ST_OVERTEMP_BIT = 0;
   localparam int ST_REFFAULT_BIT = 1;
   // reset values
   localparam logic [15:0] RST_VDAC_CODE = 16'h0000;
   localparam logic [3:0] RST_VDAC_CTL = 4'h0;
   localparam logic [10:0] RST_IDAC_CODE = 11'h000;
   localparam logic [1:0] RST_IDAC_CTL = 2'h0;
   localparam logic [1:0] RST_IRQ = 2'h0;
   // range encodings
   localparam logic [1:0] RANGE_INT = 2'h0;
   localparam logic [1:0] RANGE_SUPPLY = 2'h3;

   typedef struct packed {
      logic update_timer;
      logic mode_normal;
      logic [1:0] range;
   } dic_vdac_ctl_t;

   typedef struct packed {
      logic supply;
      logic external;
      logic internal;
   } dic_ref_sel_t;

   typedef struct packed {
      logic [11:0] code;
      logic [3:0] frac;
      dic_ref_sel_t ref_sel;
   } dic_vdac_out_t;

   typedef enum logic [1:0] {
      DIC_BUS_IDLE = 2'b01,
      DIC_BUS_WAIT = 2'b10
   } dic_bus_state_t;
endpackage : dic_pkg

// ---- design/dic_top.sv ----
/*
 dac / idac digital output control with ahb-lite register slave and interrupt.
 assumes analog trip inputs are asynchronous; timer_tick and core_reset_req are on hclk.
*/
`timescale 1ns/1ps
module dic_top #(
   parameter int N_VDAC = dic_pkg::N_VDAC,
   parameter int N_IDAC = dic_pkg::N_IDAC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic core_reset_req,
   input wire logic timer_tick,
   input wire logic overtemp_trip,
   input wire logic ref_resistor_low,
   output dic_pkg::dic_vdac_out_t vdac_out [N_VDAC],
   output logic [10:0] idac_code_out [N_IDAC],
   output logic [N_IDAC-1:0] idac_stage_en,
   output logic hc_idac_power_on,
   output logic hc_idac_current_off,
   output logic ref_fault,
   output logic irq
);
   dic_pkg::dic_bus_state_t state_q;
   logic [7:0] addr_q;
   logic write_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic [15:0] vcode_q [N_VDAC];
   dic_pkg::dic_vdac_ctl_t vctl_q [N_VDAC];
   logic [10:0] icode_q [N_IDAC];
   logic [1:0] ictl_q;
   logic ot_flag_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic ot_s1_q, ot_s2_q, ot_s3_q;
   logic rf_s1_q, rf_s2_q, rf_s3_q;
   logic ref_fault_q, irq_q, hc_on_q, hc_off_q;
   logic [N_IDAC-1:0] stage_en_q;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   wire accept = hsel & htrans[1] & hready & (state_q == dic_pkg::DIC_BUS_IDLE);
   wire wr_en = (state_q == dic_pkg::DIC_BUS_WAIT) & write_q;
   wire hit_ictl = (addr_q == dic_pkg::OFF_IDAC_CTL);
   wire hit_stat = (addr_q == dic_pkg::OFF_STATUS);
   wire hit_irqs = (addr_q == dic_pkg::OFF_IRQ_STAT);
   wire hit_irqm = (addr_q == dic_pkg::OFF_IRQ_MASK);
   wire ot_rise = ot_s2_q & ~ot_s3_q;
   wire rf_rise = rf_s2_q & ~rf_s3_q;
   wire [1:0] irq_ev = {rf_rise, ot_rise};
   wire [1:0] irq_stat_d = irq_ev | (irq_stat_q & ~({2{wr_en & hit_irqs}} & hwdata[1:0]));

   logic [31:0] rd_vcode [N_VDAC];
   logic [31:0] rd_vctl [N_VDAC];
   logic [31:0] rd_icode [N_IDAC];
   logic [31:0] rdata_d;

   // ahb-lite slave: one wait state per transfer, always okay
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q <= dic_pkg::DIC_BUS_IDLE;
         addr_q <= 8'h00;
         write_q <= 1'b0;
         hrdata_q <= 32'h00000000;
         hreadyout_q <= 1'b1;
      end
      else
      begin
         unique case (state_q)
            dic_pkg::DIC_BUS_IDLE:
            begin
               if (accept)
               begin
                  state_q <= dic_pkg::DIC_BUS_WAIT;
                  addr_q <= haddr[7:0];
                  write_q <= hwrite;
                  hreadyout_q <= 1'b0;
               end
            end
            dic_pkg::DIC_BUS_WAIT:
            begin
               state_q <= dic_pkg::DIC_BUS_IDLE;
               hrdata_q <= write_q ? 32'h00000000 : rdata_d;
               hreadyout_q <= 1'b1;
            end
         endcase
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < N_VDAC; gi++)
      begin : g_vdac
         wire hit_code = (addr_q == dic_pkg::OFF_VDAC_CODE + 8'(gi * 4));
         wire hit_ctl = (addr_q == dic_pkg::OFF_VDAC_CTL + 8'(gi * 4));
         wire [1:0] rng = vctl_q[gi].range;
         wire upd_now = ~vctl_q[gi].update_timer | timer_tick;
         // reserved bits read as zero
         // reserved zero
         assign rd_vcode[gi] = hit_code ? {4'h0, vcode_q[gi], 12'h000} : 32'h00000000;
         assign rd_vctl[gi] = hit_ctl ? {26'h0, vctl_q[gi].update_timer, 1'b0,
                                        vctl_q[gi].mode_normal, 1'b0, rng} : 32'h00000000;
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               vcode_q[gi] <= dic_pkg::RST_VDAC_CODE;
               vctl_q[gi] <= dic_pkg::RST_VDAC_CTL;
            end
            else if (core_reset_req)
            begin
               vcode_q[gi] <= dic_pkg::RST_VDAC_CODE;
               vctl_q[gi] <= dic_pkg::RST_VDAC_CTL;
            end
            else
            begin
               if (wr_en & hit_code)
                  vcode_q[gi] <= hwdata[dic_pkg::CODE_MSB:dic_pkg::FRAC_LSB];
               if (wr_en & hit_ctl)
                  vctl_q[gi] <= {hwdata[dic_pkg::CTL_UPD_BIT], hwdata[dic_pkg::CTL_MODE_BIT],
                                 hwdata[dic_pkg::CTL_RANGE_LSB +: 2]};
            end
         end
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               vdac_out[gi] <= '0;
            else if (upd_now)
            begin
               vdac_out[gi].code <= vcode_q[gi][15:4];
               vdac_out[gi].frac <= vctl_q[gi].mode_normal ? 4'h0 : vcode_q[gi][3:0];
               vdac_out[gi].ref_sel <= {rng == dic_pkg::RANGE_SUPPLY,
                                        rng != dic_pkg::RANGE_SUPPLY && rng != dic_pkg::RANGE_INT,
                                        rng == dic_pkg::RANGE_INT};
            end
         end
         chk_timer_hold: assert property (vctl_q[gi].update_timer && !timer_tick
            |=> $stable(vdac_out[gi])) else $error("dac output moved without timer tick");
         chk_code_field: assert property (!vctl_q[gi].update_timer
            |=> vdac_out[gi].code == $past(vcode_q[gi][15:4]))
            else $error("dac code not taken from data bits");
         chk_frac_mode: assert property (!vctl_q[gi].update_timer
            && vctl_q[gi].mode_normal
            |=> vdac_out[gi].frac == 4'h0) else $error("fraction used in normal mode");
         chk_range_decode: assert property (!vctl_q[gi].update_timer && rng == 2'h2
            |=> vdac_out[gi].ref_sel == 3'h2) else $error("range 10 not external");
      end
      for (gi = 0; gi < N_IDAC; gi++)
      begin : g_idac
         wire hit_code = (addr_q == dic_pkg::OFF_IDAC_CODE + 8'(gi * 4));
         assign rd_icode[gi] = hit_code ? {21'h0, icode_q[gi]} : 32'h00000000;
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               icode_q[gi] <= dic_pkg::RST_IDAC_CODE;
            else if (core_reset_req)
               icode_q[gi] <= dic_pkg::RST_IDAC_CODE;
            else if (wr_en & hit_code)
               icode_q[gi] <= hwdata[dic_pkg::IDAC_W-1:0];
         end
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               idac_code_out[gi] <= dic_pkg::RST_IDAC_CODE;
            else
               idac_code_out[gi] <= icode_q[gi];
         end
         chk_idac_code: assert property (wr_en && hit_code && !core_reset_req
            |=> ##1 idac_code_out[gi] == $past(hwdata[10:0], 2))
            else $error("idac code not carried to output");
      end
   endgenerate

   always_comb
   begin
      rdata_d = 32'h00000000;
      for (int i = 0; i < N_VDAC; i++)
         rdata_d = rdata_d | rd_vcode[i] | rd_vctl[i];
      for (int i = 0; i < N_IDAC; i++)
         rdata_d = rdata_d | rd_icode[i];
      if (hit_ictl)
         rdata_d = {30'h0, ictl_q};
      if (hit_stat)
         rdata_d = {30'h0, ref_fault_q, ot_flag_q};
      if (hit_irqs)
         rdata_d = {30'h0, irq_stat_q};
      if (hit_irqm)
         rdata_d = {30'h0, irq_mask_q};
   end

   // analog inputs pass two flops first
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {ot_s1_q, ot_s2_q, ot_s3_q} <= 3'h0;
         {rf_s1_q, rf_s2_q, rf_s3_q} <= 3'h0;
      end
      else
      begin
         {ot_s1_q, ot_s2_q, ot_s3_q} <= {overtemp_trip, ot_s1_q, ot_s2_q};
         {rf_s1_q, rf_s2_q, rf_s3_q} <= {ref_resistor_low, rf_s1_q, rf_s2_q};
      end
   end

   // control, mask and interrupt status
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ictl_q <= dic_pkg::RST_IDAC_CTL;
         irq_mask_q <= dic_pkg::RST_IRQ;
         irq_stat_q <= dic_pkg::RST_IRQ;
      end
      else if (core_reset_req)
      begin
         ictl_q <= dic_pkg::RST_IDAC_CTL;
         irq_mask_q <= dic_pkg::RST_IRQ;
         irq_stat_q <= irq_ev;
      end
      else
      begin
         if (wr_en & hit_ictl)
            ictl_q <= {hwdata[dic_pkg::IDAC_SW_BIT], hwdata[dic_pkg::IDAC_EN_BIT]};
         if (wr_en & hit_irqm)
            irq_mask_q <= hwdata[1:0];
         irq_stat_q <= irq_stat_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ot_flag_q <= 1'b0;
      else if (ot_s2_q)
         ot_flag_q <= 1'b1;
      else if (wr_en & hit_stat & ~hwdata[dic_pkg::ST_OVERTEMP_BIT])
         ot_flag_q <= 1'b0;
   end

   // output drivers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stage_en_q <= '0;
         hc_on_q <= 1'b0;
         hc_off_q <= 1'b1;
         ref_fault_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         stage_en_q <= {N_IDAC{~ot_s2_q & ~ot_flag_q}};
         hc_on_q <= ictl_q[dic_pkg::IDAC_EN_BIT] & ~ot_s2_q & ~ot_flag_q;
         hc_off_q <= ictl_q[dic_pkg::IDAC_SW_BIT] | ~ictl_q[dic_pkg::IDAC_EN_BIT] | ot_s2_q;
         ref_fault_q <= rf_s2_q;
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign idac_stage_en = stage_en_q;
   assign hc_idac_power_on = hc_on_q;
   assign hc_idac_current_off = hc_off_q;
   assign ref_fault = ref_fault_q;
   assign irq = irq_q;

   sequence seq_accept;
      accept;
   endsequence
   sequence seq_wait_then_ready;
      !hreadyout ##1 hreadyout;
   endsequence

   chk_bus_wait: assert property (seq_accept |=> seq_wait_then_ready)
      else $error("bus answer not after one wait state");
   chk_overtemp_stages: assert property (ot_s2_q |=> idac_stage_en == '0)
      else $error("idac stages on during trip");
   chk_overtemp_flag: assert property (ot_rise && irq_mask_q[0] |=> ot_flag_q ##1 irq)
      else $error("trip did not set flag and interrupt");
   chk_flag_retained: assert property (core_reset_req && ot_flag_q |=> ot_flag_q)
      else $error("overtemp flag lost on core reset");
   chk_flag_clear: assert property (wr_en && hit_stat && !hwdata[0] && !ot_s2_q
      |=> !ot_flag_q) else $error("overtemp flag not cleared by zero write");
   chk_hc_idac_off: assert property (!ictl_q[0] |=> !hc_idac_power_on)
      else $error("high current idac on while not enabled");
   chk_switch_off: assert property (ictl_q[1] |=> hc_idac_current_off)
      else $error("idac current not off with switch on");
   chk_ref_fault: assert property (rf_s2_q |=> ref_fault)
      else $error("reference fault not raised");
   chk_reserved_zero: assert property (state_q == dic_pkg::DIC_BUS_WAIT && !write_q
      && addr_q[1:0] == 2'h0 && addr_q < 8'(dic_pkg::OFF_VDAC_CODE + N_VDAC * 4)
      |=> hrdata[31:28] == 4'h0 && hrdata[11:0] == 12'h000)
      else $error("reserved data bits not zero");
endmodule : dic_top

// ---- test/dic_top_test.sv ----
/*
 self-checking bench for the dac / idac output control block.
 assumes one ahb-lite slave whose hreadyout is the bus hready, and a 125 MHz hclk.
*/
`timescale 1ns/1ps
module dic_top_test;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic hresp;
   logic core_reset_req = 1'b0;
   logic timer_tick = 1'b0;
   logic overtemp_trip = 1'b0;
   logic ref_resistor_low = 1'b0;
   dic_pkg::dic_vdac_out_t vdac_out [dic_pkg::N_VDAC];
   logic [10:0] idac_code_out [dic_pkg::N_IDAC];
   logic [dic_pkg::N_IDAC-1:0] idac_stage_en;
   logic hc_idac_power_on;
   logic hc_idac_current_off;
   logic ref_fault;
   logic irq;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] rdv;

   always #4 hclk = ~hclk;

   dic_top dic_top_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .core_reset_req(core_reset_req),
      .timer_tick(timer_tick), .overtemp_trip(overtemp_trip),
      .ref_resistor_low(ref_resistor_low), .vdac_out(vdac_out),
      .idac_code_out(idac_code_out), .idac_stage_en(idac_stage_en),
      .hc_idac_power_on(hc_idac_power_on), .hc_idac_current_off(hc_idac_current_off),
      .ref_fault(ref_fault), .irq(irq)
   );

   task automatic wrap_up;
      if (bad_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc

   // hready and hrdata are sampled at the rising edge that ends the phase
   task automatic wait_ready;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      rdv = hrdata;
   endtask : wait_ready

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(nm, exp, rdv);
   endtask : rd_chk

   task automatic t_reset;
      chk("hc_power_on", 32'h0, hc_idac_power_on);
      chk("hc_current_off", 32'h1, hc_idac_current_off);
      chk("hresp", 32'h0, hresp);
      rd_chk("vdac_code0", 8'h00, 32'h0);
      rd_chk("status", 8'hA4, 32'h0);
      rd_chk("unmapped", 8'hF0, 32'h0);
   endtask : t_reset

   task automatic t_data;
      wr(8'h0C, 32'hA5A5C3C3);
      rd_chk("vdac_code3", 8'h0C, 32'h05A5C000);
      cyc(4);
      chk("code3", 32'h5A5, vdac_out[3].code);
      chk("frac3", 32'hC, vdac_out[3].frac);
      wr(8'h4C, 32'h8);
      cyc(4);
      chk("frac3_normal", 32'h0, vdac_out[3].frac);
   endtask : t_data

   task automatic t_range;
      logic [2:0] exp;
      for (int r = 0; r < 4; r++)
      begin
         wr(8'h4C, 32'h8 | r);
         cyc(4);
         exp = (r == 0) ? 3'b001 : ((r == 3) ? 3'b100 : 3'b010);
         chk("ref_sel3", exp, vdac_out[3].ref_sel);
      end
      chk("ref_sel0", 32'h1, vdac_out[0].ref_sel);
   endtask : t_range

   task automatic t_update;
      wr(8'h54, 32'h20);
      wr(8'h14, 32'h07FF0000);
      cyc(6);
      chk("code5_held", 32'h0, vdac_out[5].code);
      timer_tick <= 1'b1;
      @(posedge hclk);
      timer_tick <= 1'b0;
      cyc(3);
      chk("code5_tick", 32'h7FF, vdac_out[5].code);
   endtask : t_update

   task automatic t_idac;
      wr(8'h88, 32'hFFFFFFFF);
      rd_chk("idac_code2", 8'h88, 32'h7FF);
      cyc(3);
      chk("idac_out2", 32'h7FF, idac_code_out[2]);
      wr(8'hA0, 32'h1);
      cyc(3);
      chk("hc_power_on", 32'h1, hc_idac_power_on);
      chk("hc_current_off", 32'h0, hc_idac_current_off);
      wr(8'hA0, 32'h3);
      cyc(3);
      chk("hc_switch_off", 32'h1, hc_idac_current_off);
   endtask : t_idac

   task automatic t_ref;
      ref_resistor_low <= 1'b1;
      cyc(5);
      chk("ref_fault", 32'h1, ref_fault);
      rd_chk("status_ref", 8'hA4, 32'h2);
      ref_resistor_low <= 1'b0;
      cyc(5);
      chk("ref_fault_off", 32'h0, ref_fault);
   endtask : t_ref

   task automatic t_thermal;
      wr(8'hA8, 32'h3);
      overtemp_trip <= 1'b1;
      cyc(6);
      chk("stage_en", 32'h0, idac_stage_en);
      chk("hc_power_trip", 32'h0, hc_idac_power_on);
      chk("irq_masked", 32'h0, irq);
      rd_chk("status_ot", 8'hA4, 32'h1);
      wr(8'hAC, 32'h1);
      cyc(2);
      chk("irq", 32'h1, irq);
      overtemp_trip <= 1'b0;
      wr(8'hA8, 32'h1);
      cyc(2);
      chk("irq_cleared", 32'h0, irq);
      core_reset_req <= 1'b1;
      @(posedge hclk);
      core_reset_req <= 1'b0;
      cyc(4);
      rd_chk("status_kept", 8'hA4, 32'h1);
      chk("stage_en_kept", 32'h0, idac_stage_en);
      rd_chk("code_cleared", 8'h0C, 32'h0);
      wr(8'hA4, 32'h0);
      cyc(3);
      rd_chk("status_clr", 8'hA4, 32'h0);
      chk("stage_en_on", 32'h1F, idac_stage_en);
      wr(8'hAC, 32'h1);
      wr(8'hA0, 32'h1);
      overtemp_trip <= 1'b1;
      cyc(6);
      chk("irq_trip2", 32'h1, irq);
      chk("hc_power_trip2", 32'h0, hc_idac_power_on);
      overtemp_trip <= 1'b0;
      cyc(4);
      hresetn <= 1'b0;
      cyc(2);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("hc_power_hard", 32'h0, hc_idac_power_on);
      chk("hc_off_hard", 32'h1, hc_idac_current_off);
      rd_chk("status_hard", 8'hA4, 32'h0);
   endtask : t_thermal

   initial
   begin
      cyc(12);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_data();
      t_range();
      t_update();
      t_idac();
      t_ref();
      t_thermal();
      wrap_up();
   end
endmodule : dic_top_test
